// File: fpe_pkg.sv
package fpe_pkg;

	// =====================================================================
	// register map
	localparam logic [15:0] CTRL_ADDR    = 16'hfe0b;
	localparam logic [15:0] PROTECT_ADDR = 16'hff80;
	localparam logic [15:0] ARRAY_LO     = 16'h8000;
	localparam logic [7:0]  CTRL_RESET   = 8'h00;

	// control register fields
	localparam int BIT_DIV_HI  = 7;
	localparam int BIT_DIV_LO  = 6;
	localparam int BIT_SIZE_HI = 5;
	localparam int BIT_SIZE_LO = 4;
	localparam int BIT_HIGH_VOLT_ENABLE    = 3;
	localparam int BIT_MARGIN  = 2;
	localparam int BIT_ERASE   = 1;
	localparam int BIT_PROGRAM = 0;

	// =====================================================================
	// protection start addresses per protect bit
	localparam logic [15:0] PROT_START_3 = 16'hc000;
	localparam logic [15:0] PROT_START_2 = 16'ha000;
	localparam logic [15:0] PROT_START_1 = 16'h9000;
	localparam logic [15:0] PROT_START_0 = 16'h8000;

	// =====================================================================
	// timing
	localparam int PAGE_BYTES     = 8;
	localparam int MARGIN_EXTRA   = 8;
	localparam int CLK_MHZ        = 10;
	localparam logic [2:0] MARGIN_LAST = 3'h7;

	typedef enum logic [1:0] {
		FPE_ERASE_FULL = 2'b00,
		FPE_ERASE_HALF = 2'b01,
		FPE_ERASE_OCT  = 2'b10,
		FPE_ERASE_ROW  = 2'b11
	} fpe_size_type;

endpackage

// File: fpe_pump_div.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// charge-pump clock divider
module fpe_pump_div (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic [1:0] div_sel,
	input  wire logic       run,
	output logic            pump_clk
);

	logic [1:0] cnt_r;
	logic       pump_r;
	wire  logic bypass = (div_sel == 2'b00);
	wire  logic div4   = (div_sel == 2'b11);

	// 00 passes the bus clock, 01/10 halve it, 11 quarters it
	always_ff @(posedge mclk) begin
		if (!rst_n || !run) begin
			cnt_r  <= 2'h0;
			pump_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_r + 2'h1;
			pump_r <= div4 ? cnt_r[1] : ~pump_r;
		end
	end

	// divide-by-one is gated clock; fine for analog pump, not for logic
	assign pump_clk = bypass ? (mclk & run) : pump_r;

endmodule

`default_nettype wire

// File: fpe_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module fpe_ctrl (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [15:0] bus_addr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [7:0]  bus_rdata,
	output logic             bus_wait,
	input  wire logic [7:0]  protect_byte,
	input  wire logic [7:0]  array_rdata,
	input  wire logic        hv_detect,
	output logic             array_hv,
	output logic             pump_clk,
	output logic             array_erase,
	output logic             array_program,
	output logic             array_margin,
	output logic [1:0]       erase_size,
	output logic [15:0]      erase_addr,
	output logic [12:0]      page_base,
	output logic [63:0]      page_data,
	output logic [7:0]       page_loaded,
	output logic             watchdog_run
);

	// =====================================================================
	// storage
	logic [7:0]  ctrl_r;
	logic [7:0]  prot_r;
	logic        prot_seen_r;
	logic        erase_armed_r;
	logic [15:0] erase_addr_r;
	logic [12:0] page_base_r;
	logic [63:0] page_data_r;
	logic [7:0]  page_loaded_r;
	logic [2:0]  margin_cnt_r;
	logic        margin_busy_r;
	logic [7:0]  rdata_r;
	logic [2:0]  hvd_s1_r;
	logic        hv_bypass_r;

	// =====================================================================
	// decode
	wire logic ctrl_hit  = (bus_addr == fpe_pkg::CTRL_ADDR);
	wire logic prot_hit  = (bus_addr == fpe_pkg::PROTECT_ADDR);
	wire logic array_hit = (bus_addr >= fpe_pkg::ARRAY_LO) && !ctrl_hit;
	wire logic wr_ctrl   = bus_wr && ctrl_hit;
	// the protect byte takes page writes only under the bypass
	wire logic wr_array  = bus_wr && array_hit &&
		(!prot_hit || hv_bypass_r);
	wire logic rd_prot   = bus_rd && prot_hit;
	wire logic rd_array  = bus_rd && array_hit && !prot_hit;

	// detect pin passes three stages; level moves when 2nd and 3rd agree
	wire logic hv_bypass = hv_bypass_r;

	wire logic cur_pgm = ctrl_r[fpe_pkg::BIT_PROGRAM];
	wire logic cur_ers = ctrl_r[fpe_pkg::BIT_ERASE];
	wire logic cur_hv  = ctrl_r[fpe_pkg::BIT_HIGH_VOLT_ENABLE];

	// =====================================================================
	// protection
	// lowest start of any set bit among bits 0 to 3; bits 7:4 are ignored; union equals lowest range
	function automatic logic [16:0] prot_start(input logic [7:0] p);
		if (p[0])
			prot_start = {1'b0, fpe_pkg::PROT_START_0};
		else if (p[1])
			prot_start = {1'b0, fpe_pkg::PROT_START_1};
		else if (p[2])
			prot_start = {1'b0, fpe_pkg::PROT_START_2};
		else if (p[3])
			prot_start = {1'b0, fpe_pkg::PROT_START_3};
		else
			prot_start = 17'h10000;
	endfunction

	// top end of the block that the given size erases
	function automatic logic [15:0] blk_top(input logic [15:0] a,
			input logic [1:0] s);
		unique case (s)
			fpe_pkg::FPE_ERASE_FULL: blk_top = 16'hffff;
			fpe_pkg::FPE_ERASE_HALF: blk_top = {a[15:14], 14'h3fff};
			fpe_pkg::FPE_ERASE_OCT:  blk_top = {a[15:9], 9'h1ff};
			fpe_pkg::FPE_ERASE_ROW:  blk_top = {a[15:6], 6'h3f};
		endcase
	endfunction

	wire logic [16:0] lock_from = prot_start(prot_r);
	wire logic [15:0] ers_top   = blk_top(erase_addr_r, ctrl_r[5:4]);
	wire logic [15:0] pg_top    = {page_base_r, 3'h7};
	// protect byte lives at the top; it sits inside any locked range
	wire logic ers_locked = !hv_bypass && erase_armed_r &&
		({1'b0, ers_top} >= lock_from);
	wire logic pgm_locked = !hv_bypass && (page_loaded_r != 8'h00) &&
		({1'b0, pg_top} >= lock_from);

	// =====================================================================
	// control register next value
	// pulse and settle waits are counted by software; no timers here
	logic [7:0] ctrl_nxt;
	logic       want_pgm;
	logic       want_ers;
	logic       hv_ok;
	always_comb begin
		ctrl_nxt = ctrl_r;
		want_pgm = bus_wdata[fpe_pkg::BIT_PROGRAM];
		want_ers = bus_wdata[fpe_pkg::BIT_ERASE];
		hv_ok    = 1'b0;
		if (wr_ctrl) begin
			ctrl_nxt[7:4] = bus_wdata[7:4];
			// already-set select holds; new one is refused
			if (want_pgm && want_ers) begin
				want_pgm = cur_pgm;
				want_ers = !cur_pgm && cur_ers;
			end else if (want_pgm && cur_ers) begin
				want_pgm = 1'b0;
			end else if (want_ers && cur_pgm) begin
				want_ers = 1'b0;
			end
			ctrl_nxt[fpe_pkg::BIT_PROGRAM] = want_pgm;
			ctrl_nxt[fpe_pkg::BIT_ERASE]   = want_ers;
			// select held through, protect read, target set
			hv_ok = prot_seen_r &&
				((cur_pgm && want_pgm && page_loaded_r != 8'h00) ||
				 (cur_ers && want_ers && erase_armed_r));
			ctrl_nxt[fpe_pkg::BIT_HIGH_VOLT_ENABLE] = bus_wdata[fpe_pkg::BIT_HIGH_VOLT_ENABLE] &&
				(hv_ok || cur_hv) && (want_pgm || want_ers);
			ctrl_nxt[fpe_pkg::BIT_MARGIN] =
				bus_wdata[fpe_pkg::BIT_MARGIN] &&
				!ctrl_nxt[fpe_pkg::BIT_HIGH_VOLT_ENABLE] && !cur_hv;
		end
		if (ers_locked)
			ctrl_nxt[fpe_pkg::BIT_ERASE] = 1'b0;
		if (pgm_locked)
			ctrl_nxt[fpe_pkg::BIT_PROGRAM] = 1'b0;
		if (!ctrl_nxt[fpe_pkg::BIT_PROGRAM] &&
				!ctrl_nxt[fpe_pkg::BIT_ERASE])
			ctrl_nxt[fpe_pkg::BIT_HIGH_VOLT_ENABLE] = 1'b0;
	end

	wire logic sel_rise = (ctrl_nxt[1:0] != 2'b00) && (ctrl_r[1:0] == 2'b00);
	wire logic [2:0] slot = bus_addr[2:0];

	// =====================================================================
	// sequential
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_r      <= fpe_pkg::CTRL_RESET;
			hvd_s1_r    <= 3'h0;
			hv_bypass_r <= 1'b0;
		end else begin
			ctrl_r   <= ctrl_nxt;
			hvd_s1_r <= {hvd_s1_r[1:0], hv_detect};
			if (hvd_s1_r[1] == hvd_s1_r[2])
				hv_bypass_r <= hvd_s1_r[2];
		end
	end

	// protect byte latched on read, only counts after a select
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			prot_r      <= 8'h00;
			prot_seen_r <= 1'b0;
		end else if (ctrl_nxt[1:0] == 2'b00 || sel_rise) begin
			prot_seen_r <= 1'b0;
		end else if (rd_prot) begin
			prot_r      <= protect_byte;
			prot_seen_r <= 1'b1;
		end
	end

	// erase target: cared bits kept, data dropped
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			erase_addr_r  <= 16'h0000;
			erase_armed_r <= 1'b0;
		end else if (!ctrl_r[fpe_pkg::BIT_ERASE]) begin
			erase_armed_r <= 1'b0;
		end else if (wr_array && !cur_hv) begin
			erase_addr_r  <= bus_addr;
			erase_armed_r <= 1'b1;
		end
	end

	// page buffer on an 8-byte boundary
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			page_base_r   <= 13'h0000;
			page_data_r   <= 64'h0;
			page_loaded_r <= 8'h00;
		end else if (!ctrl_r[fpe_pkg::BIT_PROGRAM]) begin
			page_loaded_r <= 8'h00;
		end else if (wr_array && !cur_hv) begin
			page_base_r   <= bus_addr[15:3];
			page_data_r[slot*8 +: 8] <= bus_wdata;
			page_loaded_r <= ((page_base_r == bus_addr[15:3]) ?
				page_loaded_r : 8'h00) | (8'h01 << slot);
		end
	end

	// margin read stretch counter
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			margin_busy_r <= 1'b0;
			margin_cnt_r  <= 3'h0;
		end else if (margin_busy_r) begin
			margin_cnt_r  <= margin_cnt_r + 3'h1;
			margin_busy_r <= (margin_cnt_r != fpe_pkg::MARGIN_LAST);
		end else if (rd_array && ctrl_r[fpe_pkg::BIT_MARGIN]) begin
			margin_busy_r <= 1'b1;
			margin_cnt_r  <= 3'h0;
		end
	end

	// =====================================================================
	// read data; array data passes as sensed, erased bit is zero
	always_ff @(posedge mclk) begin
		if (!rst_n)
			rdata_r <= 8'h00;
		else if (ctrl_hit)
			rdata_r <= ctrl_r;
		else if (prot_hit)
			rdata_r <= protect_byte;
		else if (array_hit)
			rdata_r <= array_rdata;
		else
			rdata_r <= 8'h00;
	end

	assign bus_rdata = rdata_r;
	// stall the read; watchdog is never held back by it
	assign bus_wait      = margin_busy_r ||
		(rd_array && ctrl_r[fpe_pkg::BIT_MARGIN]);
	assign watchdog_run  = 1'b1;
	assign array_hv      = ctrl_r[fpe_pkg::BIT_HIGH_VOLT_ENABLE];
	assign array_erase   = ctrl_r[fpe_pkg::BIT_ERASE];
	assign array_program = ctrl_r[fpe_pkg::BIT_PROGRAM];
	assign array_margin  = ctrl_r[fpe_pkg::BIT_MARGIN];
	assign erase_size    = ctrl_r[5:4];
	assign erase_addr    = erase_addr_r;
	assign page_base     = page_base_r;
	assign page_data     = page_data_r;
	assign page_loaded   = page_loaded_r;

	fpe_pump_div u_div (
		.mclk     (mclk),
		.rst_n    (rst_n),
		.div_sel  (ctrl_r[7:6]),
		.run      (ctrl_r[fpe_pkg::BIT_HIGH_VOLT_ENABLE]),
		.pump_clk (pump_clk)
	);

endmodule

`default_nettype wire

// File: fpe_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// control-logic properties
module fpe_ctrl_props (
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0]  bus_wdata,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [7:0]  bus_rdata,
	input wire logic        bus_wait,
	input wire logic [7:0]  array_rdata,
	input wire logic        array_hv,
	input wire logic        array_erase,
	input wire logic        array_program,
	input wire logic        array_margin,
	input wire logic [1:0]  erase_size,
	input wire logic [15:0] erase_addr,
	input wire logic [63:0] page_data,
	input wire logic        watchdog_run
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// protect byte and control register excluded: they decode apart
	wire arr = bus_addr >= fpe_pkg::ARRAY_LO &&
		bus_addr != fpe_pkg::CTRL_ADDR && bus_addr != fpe_pkg::PROTECT_ADDR;
	wire [15:0] cared = erase_size == 2'b00 ? 16'h0000 :
		erase_size == 2'b01 ? 16'h4000 :
		erase_size == 2'b10 ? 16'h7e00 : 16'h7fc0;
	// run of consecutive wait cycles; a margin read holds the bus for nine
	logic [3:0] wait_run_r;
	always_ff @(posedge mclk) begin
		if (!rst_n || !bus_wait)
			wait_run_r <= 4'h0;
		else
			wait_run_r <= wait_run_r + 4'h1;
	end

	property p_interlock; !(array_erase && array_program); endproperty
	a_interlock: assert property (p_interlock) else $error("both selects");
	property p_margin_hv; array_hv |-> !array_margin; endproperty
	a_margin_hv: assert property (p_margin_hv) else $error("margin with hv");
	property p_hv_select;
		$rose(array_hv) |-> $past(array_erase || array_program);
	endproperty
	a_hv_select: assert property (p_hv_select) else $error("hv no select");
	property p_stretch;
		bus_rd && array_margin && arr |-> ##9 !bus_wait;
	endproperty
	a_stretch: assert property (p_stretch) else $error("margin stretch");
	property p_stretch_len; $fell(bus_wait) |-> wait_run_r == 4'h9; endproperty
	a_stretch_len: assert property (p_stretch_len) else $error("stretch length");
	property p_watchdog; bus_wait |-> watchdog_run; endproperty
	a_watchdog: assert property (p_watchdog) else $error("watchdog held");
	property p_read;
		bus_rd && arr && !array_margin |=> bus_rdata == $past(array_rdata);
	endproperty
	a_read: assert property (p_read) else $error("array read data");
	property p_page;
		bus_wr && arr && array_program && !array_hv |=>
			page_data[8 * $past(bus_addr[2:0]) +: 8] == $past(bus_wdata);
	endproperty
	a_page: assert property (p_page) else $error("page byte");
	property p_erase;
		bus_wr && arr && array_erase && !array_hv |=>
			((erase_addr ^ $past(bus_addr)) & cared) == 16'h0000;
	endproperty
	a_erase: assert property (p_erase) else $error("erase address");
	c_hv: cover property ($rose(array_hv));
	c_margin: cover property (bus_rd && array_margin && arr);
	c_erase: cover property (bus_wr && arr && array_erase);
endmodule

`default_nettype wire

// File: fpe_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// bench for the program and erase control logic
module fpe_ctrl_test;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0]  bus_wdata = 8'h00;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [7:0]  protect_byte = 8'h00;
	logic [7:0]  array_rdata = 8'h00;
	logic        hv_detect = 1'b0;
	logic [7:0]  bus_rdata, page_loaded, rv;
	logic        bus_wait, array_hv, pump_clk, array_erase;
	logic        array_program, array_margin, watchdog_run;
	logic [1:0]  erase_size;
	logic [15:0] erase_addr;
	logic [12:0] page_base;
	logic [63:0] page_data;
	int          errors = 0, cmp_count = 0, waits, pumps = 0, ex, pbase;
	localparam logic [15:0] CR = fpe_pkg::CTRL_ADDR;

	always #50 mclk = ~mclk;
	always @(posedge pump_clk) pumps++;

	fpe_ctrl dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .bus_wait(bus_wait),
		.protect_byte(protect_byte), .array_rdata(array_rdata),
		.hv_detect(hv_detect), .array_hv(array_hv), .pump_clk(pump_clk),
		.array_erase(array_erase), .array_program(array_program),
		.array_margin(array_margin), .erase_size(erase_size),
		.erase_addr(erase_addr), .page_base(page_base),
		.page_data(page_data), .page_loaded(page_loaded),
		.watchdog_run(watchdog_run));

	// =====================================================================
	// access tasks
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			errors++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		bus_addr = a;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(posedge mclk);
		#1;
		bus_wr = 1'b0;
	endtask
	// strobe is one cycle; wait is counted after the taking edge
	task automatic rd(input logic [15:0] a);
		@(posedge mclk);
		#1;
		bus_addr = a;
		bus_rd = 1'b1;
		@(posedge mclk);
		#1;
		bus_rd = 1'b0;
		rv = bus_rdata;
		waits = 0;
		while (bus_wait === 1'b1 && waits < 20) begin
			@(posedge mclk);
			#1;
			waits++;
		end
		if (waits == 20) chk(1'b0, "wait hung");
	endtask
	task automatic prog_setup(input logic [15:0] a);
		wr(CR, 8'h01);
		rd(fpe_pkg::PROTECT_ADDR);
		for (int i = 0; i < 8; i++) wr(a + 16'(i), 8'(i) + 8'h30);
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// =====================================================================
	// main sequence
	initial begin
		// no interrupt source is modelled, so nothing breaks
		// one array only, so no second divider can disagree
		repeat (3) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rd(CR);
		chk(rv === fpe_pkg::CTRL_RESET, "ctrl reset");
		wr(CR, 8'h03);
		rd(CR);
		chk(rv[1:0] !== 2'b11, "both selects");
		wr(CR, 8'h08);
		rd(CR);
		chk(rv[3] === 1'b0, "hv without select");
		$display("test select done");
		// each page is programmed once, far below the row limit
		prog_setup(16'h8010);
		chk(page_loaded === 8'hff && page_base === 13'h1002, "page");
		chk(page_data === 64'h3736353433323130, "page data");
		for (int d = 0; d < 4; d++) begin
			wr(CR, {2'(d), 6'h09});
			chk(array_hv === 1'b1, "hv set");
			ex = d == 0 ? 40 : d == 3 ? 10 : 20;
			pbase = pumps;
			repeat (40) @(posedge mclk);
			chk(pumps - pbase inside {[ex - 1:ex + 1]}, "pump rate");
		end
		wr(CR, 8'hcd);
		rd(CR);
		chk(rv[2] === 1'b0 && array_margin === 1'b0, "margin");
		wr(CR, 8'hc1);
		wr(CR, 8'hc5);
		wr(CR, 8'hc4);
		rd(16'h8010);
		chk(waits == 8 && watchdog_run === 1'b1, "stretch");
		wr(CR, 8'h00);
		$display("test program done");
		for (int s = 0; s < 4; s++) begin
			wr(CR, {2'b11, 2'(s), 4'h2});
			chk(erase_size === 2'(s), "erase size");
			rd(fpe_pkg::PROTECT_ADDR);
			wr(16'hcac5, 8'h55);
			wr(CR, {2'b11, 2'(s), 4'ha});
			chk(array_hv === 1'b1, "erase hv");
			wr(CR, 8'h00);
		end
		$display("test erase done");
		protect_byte = 8'h06;
		prog_setup(16'h9008);
		chk(array_program === 1'b0, "protected");
		wr(CR, 8'h09);
		chk(array_hv === 1'b0, "hv blocked");
		wr(CR, 8'h00);
		prog_setup(16'h8ff8);
		chk(array_program === 1'b1, "open below");
		wr(CR, 8'h00);
		hv_detect = 1'b1;
		prog_setup(fpe_pkg::PROTECT_ADDR);
		chk(page_loaded === 8'hff, "protect page");
		wr(CR, 8'h09);
		chk(array_hv === 1'b1, "bypass");
		wr(CR, 8'h01);
		wr(CR, 8'h00);
		for (int i = 0; i < 500; i++) rd(16'h8100);
		rd(16'h8100);
		chk(rv === 8'h00, "erased byte");
		array_rdata = 8'ha5;
		rd(16'h8100);
		chk(rv === 8'ha5, "programmed byte");
		$display("test protect done");
		give_verdict();
	end
endmodule

bind fpe_ctrl fpe_ctrl_props u_props (.mclk(mclk), .rst_n(rst_n),
	.bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
	.array_rdata(array_rdata), .array_hv(array_hv),
	.array_erase(array_erase), .array_program(array_program),
	.array_margin(array_margin), .erase_size(erase_size),
	.erase_addr(erase_addr), .page_data(page_data),
	.watchdog_run(watchdog_run));

`default_nettype wire
